// file: hw/irq_prio_pkg.sv
/*
  Constants, register map and helper functions for the peripheral
  interrupt priority bank.
  Assumes a 32-bit classic Wishbone register bus on one 40 MHz clock.
*/
package irq_prio_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  localparam logic [ADDR_W-1:0] OFS_PRIO_TWO = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRIO_THREE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_VIEW = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_REQUEST_VIEW = 8'h18;

  // ----------------------------------------------------------------
  // Priority register layouts
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] PRIO_TWO_IMPL = 32'h0000_0095;
  localparam logic [DATA_W-1:0] PRIO_THREE_IMPL = 32'h0000_001f;
  localparam logic [DATA_W-1:0] PRIO_TWO_RESET = PRIO_TWO_IMPL;
  localparam logic [DATA_W-1:0] PRIO_THREE_RESET = PRIO_THREE_IMPL;
  localparam int OSC_FAIL_BIT = 7;
  localparam int NVM_WRITE_BIT = 4;
  localparam int LOW_VOLTAGE_BIT = 2;
  localparam int COMPARE2_BIT = 0;
  localparam int MOTOR_TB_BIT = 4;
  localparam int CAP3_DIR_BIT = 3;
  localparam int CAP2_ENC_BIT = 2;
  localparam int CAP1_BIT = 1;
  localparam int TIMER5_BIT = 0;

  // ----------------------------------------------------------------
  // Control register layout
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CONTROL_IMPL = 32'h0000_ff71;
  localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h0000_0000;
  localparam int LEVELS_ENABLE_BIT = 0;
  localparam int ENC_MODE_LSB = 4;
  localparam int ENC_MODE_W = 3;
  localparam int CAP2_CTL_LSB = 8;
  localparam int CAP3_CTL_LSB = 12;
  localparam int CAP_CTL_W = 4;

  // ----------------------------------------------------------------
  // Interrupt source indices
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 11;
  localparam int SRC_OSC_FAIL = 0;
  localparam int SRC_NVM_WRITE = 1;
  localparam int SRC_LOW_VOLTAGE = 2;
  localparam int SRC_COMPARE2 = 3;
  localparam int SRC_MOTOR_TB = 4;
  localparam int SRC_CAPTURE3 = 5;
  localparam int SRC_DIRECTION = 6;
  localparam int SRC_CAPTURE2 = 7;
  localparam int SRC_ENCODER = 8;
  localparam int SRC_CAPTURE1 = 9;
  localparam int SRC_TIMER5 = 10;

  // ----------------------------------------------------------------
  // Block events
  // ----------------------------------------------------------------
  localparam int EVT_W = 4;
  localparam int EVT_HIGH_RISE = 0;
  localparam int EVT_LOW_RISE = 1;
  localparam int EVT_SHARED_SWITCH = 2;
  localparam int EVT_RESERVED_WRITE = 3;
  localparam logic [DATA_W-1:0] EVENT_IMPL = 32'h0000_000f;

  typedef enum {FN_NONE, FN_CAPTURE, FN_ENCODER} shared_fn_t;

  // A capture or encoder mode field other than zero turns the unit on.
  function automatic logic fieldEnabled(input logic [CAP_CTL_W-1:0] field);
    return |field;
  endfunction

  // Byte mask built from the Wishbone select lines.
  function automatic logic [DATA_W-1:0] laneMask(input logic [SEL_W-1:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Merge write data into a register, keeping unimplemented bits at zero.
  function automatic logic [DATA_W-1:0] applyWrite(input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] wdata, input logic [SEL_W-1:0] sel,
      input logic [DATA_W-1:0] impl);
    logic [DATA_W-1:0] m;
    m = laneMask(sel);
    return ((old & ~m) | (wdata & m)) & impl;
  endfunction

endpackage

// file: hw/reg_access_if.sv
/*
  Register access carrier between the Wishbone slave and the register
  file of the priority bank.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/100ps
interface reg_access_if;
  import irq_prio_pkg::*;
  logic wr;
  logic rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [SEL_W-1:0] sel;
  logic [DATA_W-1:0] rdata;
  modport bus_side (output wr, output rd, output addr, output wdata, output sel,
    input rdata);
  modport reg_side (input wr, input rd, input addr, input wdata, input sel,
    output rdata);
endinterface

// file: hw/wb_reg_slave.sv
/*
  Classic Wishbone slave turning bus cycles into one-cycle register
  strobes and a registered read word.
  Assumes a master that holds its request until it sees ack.
*/
`timescale 1ns/100ps
module wb_reg_slave
  import irq_prio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic [DATA_W-1:0] dat_i,
  output logic [DATA_W-1:0] dat_o,
  output logic ack_o,
  // Register side
  reg_access_if.bus_side regs
);

  logic access;

  // The strobe fires once per cycle: ack blocks a second hit on the same request.
  assign access = cyc_i & stb_i & ~ack_o;
  assign regs.wr = access & we_i;
  assign regs.rd = access & ~we_i;
  assign regs.addr = adr_i;
  assign regs.wdata = dat_i;
  assign regs.sel = sel_i;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dat_o <= '0;
    end else if (regs.rd) begin
      dat_o <= regs.rdata;
    end
  end

endmodule

// file: hw/prio_router.sv
/*
  Combinational steering of peripheral requests onto the high and low
  priority lines.
  Assumes request inputs are already synchronous to the core clock.
*/
`timescale 1ns/100ps
module prio_router
  import irq_prio_pkg::*;
(
  // Configuration
  input wire logic [DATA_W-1:0] prioTwo,
  input wire logic [DATA_W-1:0] prioThree,
  input wire logic levelsEnable,
  input wire logic encoderOn,
  input wire logic cap2On,
  input wire logic cap3On,
  // Requests
  input wire logic [NUM_SRC-1:0] req,
  // Results
  output logic [NUM_SRC-1:0] levelHigh,
  output logic [NUM_SRC-1:0] liveReq,
  output logic highReq,
  output logic lowReq
);

  always_comb begin
    levelHigh = '0;
    levelHigh[SRC_OSC_FAIL] = prioTwo[OSC_FAIL_BIT];
    levelHigh[SRC_NVM_WRITE] = prioTwo[NVM_WRITE_BIT];
    levelHigh[SRC_LOW_VOLTAGE] = prioTwo[LOW_VOLTAGE_BIT];
    levelHigh[SRC_COMPARE2] = prioTwo[COMPARE2_BIT];
    levelHigh[SRC_MOTOR_TB] = prioThree[MOTOR_TB_BIT];
    levelHigh[SRC_CAPTURE3] = prioThree[CAP3_DIR_BIT];
    levelHigh[SRC_DIRECTION] = prioThree[CAP3_DIR_BIT];
    levelHigh[SRC_CAPTURE2] = prioThree[CAP2_ENC_BIT];
    levelHigh[SRC_ENCODER] = prioThree[CAP2_ENC_BIT];
    levelHigh[SRC_CAPTURE1] = prioThree[CAP1_BIT];
    levelHigh[SRC_TIMER5] = prioThree[TIMER5_BIT];
  end

  // A shared bit serves one function at a time; the encoder owns it when on.
  always_comb begin
    liveReq = req;
    liveReq[SRC_CAPTURE3] = req[SRC_CAPTURE3] & cap3On & ~encoderOn;
    liveReq[SRC_DIRECTION] = req[SRC_DIRECTION] & encoderOn;
    liveReq[SRC_CAPTURE2] = req[SRC_CAPTURE2] & cap2On & ~encoderOn;
    liveReq[SRC_ENCODER] = req[SRC_ENCODER] & encoderOn;
  end

  // Without levels every live request goes to the single high vector.
  always_comb begin
    if (levelsEnable) begin
      highReq = |(liveReq & levelHigh);
      lowReq = |(liveReq & ~levelHigh);
    end else begin
      highReq = |liveReq;
      lowReq = 1'b0;
    end
  end

endmodule

// file: hw/peripheral_irq_priority_bank.sv
/*
  Peripheral interrupt priority bank: two priority registers, a control
  register for levels and shared-bit modes, event status and mask, and
  registered high and low priority request outputs.
  Assumes a classic Wishbone master and synchronous request inputs.
*/
`timescale 1ns/100ps
module peripheral_irq_priority_bank
  import irq_prio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic [DATA_W-1:0] dat_i,
  output logic [DATA_W-1:0] dat_o,
  output logic ack_o,
  // Peripheral requests
  input wire logic oscFailReq,
  input wire logic nvmWriteReq,
  input wire logic lowVoltageReq,
  input wire logic compare2Req,
  input wire logic motorTimebaseReq,
  input wire logic capture3Req,
  input wire logic directionReq,
  input wire logic capture2Req,
  input wire logic encoderReq,
  input wire logic capture1Req,
  input wire logic timer5Req,
  // Priority outputs
  output logic highIrq,
  output logic lowIrq,
  // Block interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg_access_if regs ();

  logic [DATA_W-1:0] peripheral_priority_two;
  logic [DATA_W-1:0] peripheral_priority_three;
  logic [DATA_W-1:0] control;
  logic [DATA_W-1:0] eventStatus;
  logic [DATA_W-1:0] eventMask;
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] levelHigh;
  logic [NUM_SRC-1:0] liveReq;
  logic [NUM_SRC-1:0] levelView;
  logic [NUM_SRC-1:0] requestView;
  logic highReq;
  logic lowReq;
  logic priority_levels_enable;
  logic [ENC_MODE_W-1:0] encoder_mode_field;
  logic [CAP_CTL_W-1:0] capture2_control;
  logic [CAP_CTL_W-1:0] capture3_control;
  logic encoderOn;
  logic cap2On;
  logic cap3On;
  shared_fn_t bit3Fn;
  shared_fn_t bit2Fn;
  shared_fn_t prevBit3Fn;
  shared_fn_t prevBit2Fn;
  logic [EVT_W-1:0] eventSet;
  logic [DATA_W-1:0] eventClear;
  logic reservedHit;
  logic [DATA_W-1:0] next_rdata;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  wb_reg_slave u_slave (
    .clk(clk),
    .sys_rst(sys_rst),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .regs(regs.bus_side)
  );

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign priority_levels_enable = control[LEVELS_ENABLE_BIT];
  assign encoder_mode_field = control[ENC_MODE_LSB +: ENC_MODE_W];
  assign capture2_control = control[CAP2_CTL_LSB +: CAP_CTL_W];
  assign capture3_control = control[CAP3_CTL_LSB +: CAP_CTL_W];
  assign encoderOn = fieldEnabled({1'b0, encoder_mode_field});
  assign cap2On = fieldEnabled(capture2_control);
  assign cap3On = fieldEnabled(capture3_control);

  // ----------------------------------------------------------------
  // Request gathering and routing
  // ----------------------------------------------------------------
  always_comb begin
    req = '0;
    req[SRC_OSC_FAIL] = oscFailReq;
    req[SRC_NVM_WRITE] = nvmWriteReq;
    req[SRC_LOW_VOLTAGE] = lowVoltageReq;
    req[SRC_COMPARE2] = compare2Req;
    req[SRC_MOTOR_TB] = motorTimebaseReq;
    req[SRC_CAPTURE3] = capture3Req;
    req[SRC_DIRECTION] = directionReq;
    req[SRC_CAPTURE2] = capture2Req;
    req[SRC_ENCODER] = encoderReq;
    req[SRC_CAPTURE1] = capture1Req;
    req[SRC_TIMER5] = timer5Req;
  end

  prio_router u_router (
    .prioTwo(peripheral_priority_two),
    .prioThree(peripheral_priority_three),
    .levelsEnable(priority_levels_enable),
    .encoderOn(encoderOn),
    .cap2On(cap2On),
    .cap3On(cap3On),
    .req(req),
    .levelHigh(levelHigh),
    .liveReq(liveReq),
    .highReq(highReq),
    .lowReq(lowReq)
  );

  // Outputs are registered so the vector logic sees glitch-free levels.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      highIrq <= 1'b0;
      lowIrq <= 1'b0;
    end else begin
      highIrq <= highReq;
      lowIrq <= lowReq;
    end
  end

  // Level view shows high for every source while levels are off.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      levelView <= '1;
      requestView <= '0;
    end else begin
      levelView <= priority_levels_enable ? levelHigh : '1;
      requestView <= liveReq;
    end
  end

  // ----------------------------------------------------------------
  // Priority registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      peripheral_priority_two <= PRIO_TWO_RESET;
    end else if (regs.wr && regs.addr == OFS_PRIO_TWO) begin
      peripheral_priority_two <= applyWrite(peripheral_priority_two, regs.wdata,
        regs.sel, PRIO_TWO_IMPL);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      peripheral_priority_three <= PRIO_THREE_RESET;
    end else if (regs.wr && regs.addr == OFS_PRIO_THREE) begin
      peripheral_priority_three <= applyWrite(peripheral_priority_three,
        regs.wdata, regs.sel, PRIO_THREE_IMPL);
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Levels start disabled so a fresh part behaves as a single-vector core.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      control <= CONTROL_RESET;
    end else if (regs.wr && regs.addr == OFS_CONTROL) begin
      control <= applyWrite(control, regs.wdata, regs.sel, CONTROL_IMPL);
    end
  end

  // ----------------------------------------------------------------
  // Shared bit function tracking
  // ----------------------------------------------------------------
  // The encoder takes precedence when both it and a capture unit are on.
  always_comb begin
    if (encoderOn) begin
      bit3Fn = FN_ENCODER;
      bit2Fn = FN_ENCODER;
    end else begin
      bit3Fn = cap3On ? FN_CAPTURE : FN_NONE;
      bit2Fn = cap2On ? FN_CAPTURE : FN_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prevBit3Fn <= FN_NONE;
      prevBit2Fn <= FN_NONE;
    end else begin
      prevBit3Fn <= bit3Fn;
      prevBit2Fn <= bit2Fn;
    end
  end

  // ----------------------------------------------------------------
  // Events, status and mask
  // ----------------------------------------------------------------
  // Unimplemented bits of a priority write are dropped but noted.
  always_comb begin
    reservedHit = 1'b0;
    if (regs.wr) begin
      case (regs.addr)
        OFS_PRIO_TWO: begin
          reservedHit = |(regs.wdata & laneMask(regs.sel) & ~PRIO_TWO_IMPL);
        end
        OFS_PRIO_THREE: begin
          reservedHit = |(regs.wdata & laneMask(regs.sel) & ~PRIO_THREE_IMPL);
        end
        default: begin
          reservedHit = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    eventSet = '0;
    eventSet[EVT_HIGH_RISE] = highReq & ~highIrq;
    eventSet[EVT_LOW_RISE] = lowReq & ~lowIrq;
    eventSet[EVT_SHARED_SWITCH] = (bit3Fn != prevBit3Fn) | (bit2Fn != prevBit2Fn);
    eventSet[EVT_RESERVED_WRITE] = reservedHit;
  end

  assign eventClear = (regs.wr && regs.addr == OFS_EVENT_STATUS) ?
    (regs.wdata & laneMask(regs.sel)) : '0;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eventStatus <= '0;
    end else begin
      eventStatus <= ((eventStatus & ~eventClear) | {{(DATA_W-EVT_W){1'b0}}, eventSet})
        & EVENT_IMPL;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eventMask <= '0;
    end else if (regs.wr && regs.addr == OFS_EVENT_MASK) begin
      eventMask <= applyWrite(eventMask, regs.wdata, regs.sel, EVENT_IMPL);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(eventStatus & eventMask);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero; the slave still acknowledges them.
  always_comb begin
    case (regs.addr)
      OFS_PRIO_TWO: begin
        next_rdata = peripheral_priority_two;
      end
      OFS_PRIO_THREE: begin
        next_rdata = peripheral_priority_three;
      end
      OFS_CONTROL: begin
        next_rdata = control;
      end
      OFS_EVENT_STATUS: begin
        next_rdata = eventStatus;
      end
      OFS_EVENT_MASK: begin
        next_rdata = eventMask;
      end
      OFS_LEVEL_VIEW: begin
        next_rdata = {{(DATA_W-NUM_SRC){1'b0}}, levelView};
      end
      OFS_REQUEST_VIEW: begin
        next_rdata = {{(DATA_W-NUM_SRC){1'b0}}, requestView};
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  assign regs.rdata = next_rdata;

endmodule

// file: testbench/irq_prio_bank_sva.sv
/*
  Checker for the peripheral interrupt priority bank, watching only the
  top module ports. Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module irq_prio_bank_sva
  import irq_prio_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic [DATA_W-1:0] dat_i,
  input wire logic [DATA_W-1:0] dat_o,
  input wire logic ack_o,
  input wire logic oscFailReq,
  input wire logic nvmWriteReq,
  input wire logic lowVoltageReq,
  input wire logic compare2Req,
  input wire logic motorTimebaseReq,
  input wire logic capture3Req,
  input wire logic directionReq,
  input wire logic capture2Req,
  input wire logic encoderReq,
  input wire logic capture1Req,
  input wire logic timer5Req,
  input wire logic highIrq,
  input wire logic lowIrq,
  input wire logic irq
);
  logic anyReq;

  assign anyReq = oscFailReq | nvmWriteReq | lowVoltageReq | compare2Req | motorTimebaseReq
    | capture3Req | directionReq | capture2Req | encoderReq | capture1Req | timer5Req;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Bus and register properties
  // ----------------------------------------------------------------
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_ANSWER: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in the next cycle");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  AST_RESET_QUIET: assert property ($fell(sys_rst) |-> !highIrq && !lowIrq && !irq && !ack_o)
    else $error("outputs active right after reset");
  AST_TWO_UNIMPL: assert property (ack_o && !$past(we_i) && $past(adr_i) == OFS_PRIO_TWO
    |-> (dat_o & ~PRIO_TWO_IMPL) == '0)
    else $error("unimplemented bits of priority two read as one");
  AST_THREE_UNIMPL: assert property (ack_o && !$past(we_i) && $past(adr_i) == OFS_PRIO_THREE
    |-> (dat_o & ~PRIO_THREE_IMPL) == '0)
    else $error("unimplemented bits of priority three read as one");
  AST_UNMAPPED_ZERO: assert property (ack_o && !$past(we_i) && $past(adr_i) > OFS_REQUEST_VIEW
    |-> dat_o == '0)
    else $error("unmapped read not zero");
  AST_DATA_HOLD: assert property (!ack_o && !$past(sys_rst) |-> $stable(dat_o))
    else $error("read data changed without a read");

  // ----------------------------------------------------------------
  // Priority outputs
  // ----------------------------------------------------------------
  AST_NO_REQ_QUIET: assert property (!anyReq |=> !highIrq && !lowIrq)
    else $error("priority output without any request");

  COV_READ: cover property (ack_o && !$past(we_i));
  COV_HIGH: cover property ($rose(highIrq));
  COV_LOW: cover property ($rose(lowIrq));
  COV_IRQ: cover property ($rose(irq));
endmodule

bind peripheral_irq_priority_bank irq_prio_bank_sva u_irq_prio_bank_sva (
  .clk(clk), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .oscFailReq(oscFailReq),
  .nvmWriteReq(nvmWriteReq), .lowVoltageReq(lowVoltageReq), .compare2Req(compare2Req),
  .motorTimebaseReq(motorTimebaseReq), .capture3Req(capture3Req),
  .directionReq(directionReq), .capture2Req(capture2Req), .encoderReq(encoderReq),
  .capture1Req(capture1Req), .timer5Req(timer5Req), .highIrq(highIrq), .lowIrq(lowIrq),
  .irq(irq));

// file: testbench/peripheral_irq_priority_bank_test.sv
/*
  Self-checking bench for the peripheral interrupt priority bank.
  Assumes the design answers each Wishbone access one cycle after taking it.
*/
`timescale 1ns/100ps
`define CHECK_EQ(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module peripheral_irq_priority_bank_test;
  import irq_prio_pkg::*;
  logic clk, sysRst, cyc, stb, we;
  logic [ADDR_W-1:0] adr;
  logic [SEL_W-1:0] sel;
  logic [DATA_W-1:0] wdat, datOut, q;
  logic ackOut, highIrq, lowIrq, irq;
  logic [NUM_SRC-1:0] req;
  int mismatches, testsRun, cycles;

  peripheral_irq_priority_bank u_peripheral_irq_priority_bank (
    .clk(clk), .sys_rst(sysRst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(datOut), .ack_o(ackOut),
    .oscFailReq(req[SRC_OSC_FAIL]), .nvmWriteReq(req[SRC_NVM_WRITE]),
    .lowVoltageReq(req[SRC_LOW_VOLTAGE]), .compare2Req(req[SRC_COMPARE2]),
    .motorTimebaseReq(req[SRC_MOTOR_TB]), .capture3Req(req[SRC_CAPTURE3]),
    .directionReq(req[SRC_DIRECTION]), .capture2Req(req[SRC_CAPTURE2]),
    .encoderReq(req[SRC_ENCODER]), .capture1Req(req[SRC_CAPTURE1]),
    .timer5Req(req[SRC_TIMER5]), .highIrq(highIrq), .lowIrq(lowIrq), .irq(irq));

  // ----------------------------------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic print_verdict();
    if (mismatches == 0 && testsRun > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles; this ceiling leaves room.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wbXfer(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ackOut !== 1'b1);
    r = datOut;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    wbXfer(1'b1, a, d, r);
  endtask

  task automatic rdCheck(input string nm, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] r;
    wbXfer(1'b0, a, '0, r);
    `CHECK_EQ(nm, exp, r)
  endtask

  // Waits three edges so the registered outputs follow the new settings.
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [NUM_SRC-1:0] bitOf(input int i);
    return NUM_SRC'(1) << i;
  endfunction

  // Settings are written with requests idle, then one request is raised.
  task automatic runCase(input logic [15:0] ctl, input logic [7:0] p2, input logic [7:0] p3,
      input logic [NUM_SRC-1:0] r, input logic h, input logic l);
    req <= '0;
    wr(OFS_CONTROL, {16'h0000, ctl});
    wr(OFS_PRIO_TWO, {24'h000000, p2});
    wr(OFS_PRIO_THREE, {24'h000000, p3});
    @(posedge clk);
    req <= r;
    settle();
    `CHECK_EQ("highIrq", h, highIrq)
    `CHECK_EQ("lowIrq", l, lowIrq)
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    testsRun = 0;
    cycles = 0;
    sysRst = 1'b1;
    {cyc, stb, we} = 3'b000;
    adr = '0;
    sel = '0;
    wdat = '0;
    req = '0;
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    rdCheck("prioTwo", OFS_PRIO_TWO, 32'h0000_0095);
    rdCheck("prioThree", OFS_PRIO_THREE, 32'h0000_001f);
    rdCheck("control", OFS_CONTROL, 32'h0000_0000);
    wr(OFS_EVENT_MASK, 32'h0000_0008);
    wr(OFS_PRIO_TWO, 32'hffff_ffff);
    rdCheck("prioTwo", OFS_PRIO_TWO, 32'h0000_0095);
    settle();
    `CHECK_EQ("irq", 1'b1, irq)
    wr(OFS_EVENT_MASK, 32'h0000_0000);
    settle();
    `CHECK_EQ("irq", 1'b0, irq)
    wr(OFS_EVENT_MASK, 32'h0000_0008);
    settle();
    `CHECK_EQ("irq", 1'b1, irq)
    wr(OFS_EVENT_STATUS, 32'h0000_0008);
    settle();
    `CHECK_EQ("irq", 1'b0, irq)
    wr(OFS_PRIO_THREE, 32'h0000_0000);
    rdCheck("prioThree", OFS_PRIO_THREE, 32'h0000_0000);
    rdCheck("unmapped", 8'h40, 32'h0000_0000);
    wr(OFS_EVENT_MASK, 32'h0000_0000);
    runCase(16'h0001, 8'h95, 8'h01, bitOf(SRC_TIMER5), 1'b1, 1'b0);
    runCase(16'h0001, 8'h95, 8'h1e, bitOf(SRC_TIMER5), 1'b0, 1'b1);
    runCase(16'h0001, 8'h80, 8'h1f, bitOf(SRC_OSC_FAIL), 1'b1, 1'b0);
    runCase(16'h0001, 8'h15, 8'h1f, bitOf(SRC_OSC_FAIL), 1'b0, 1'b1);
    runCase(16'h1001, 8'h95, 8'h08, bitOf(SRC_CAPTURE3), 1'b1, 1'b0);
    runCase(16'h1001, 8'h95, 8'h00, bitOf(SRC_CAPTURE3), 1'b0, 1'b1);
    runCase(16'h0001, 8'h95, 8'h08, bitOf(SRC_CAPTURE3), 1'b0, 1'b0);
    runCase(16'h0011, 8'h95, 8'h08, bitOf(SRC_DIRECTION), 1'b1, 1'b0);
    runCase(16'h0011, 8'h95, 8'h00, bitOf(SRC_DIRECTION), 1'b0, 1'b1);
    runCase(16'h1011, 8'h95, 8'h08, bitOf(SRC_CAPTURE3), 1'b0, 1'b0);
    runCase(16'h0101, 8'h95, 8'h04, bitOf(SRC_CAPTURE2), 1'b1, 1'b0);
    runCase(16'h0101, 8'h95, 8'h00, bitOf(SRC_CAPTURE2), 1'b0, 1'b1);
    runCase(16'h0011, 8'h95, 8'h04, bitOf(SRC_ENCODER), 1'b1, 1'b0);
    runCase(16'h0011, 8'h95, 8'h00, bitOf(SRC_ENCODER), 1'b0, 1'b1);
    runCase(16'h0001, 8'h95, 8'h02, bitOf(SRC_CAPTURE1), 1'b1, 1'b0);
    runCase(16'h0001, 8'h95, 8'h00, bitOf(SRC_CAPTURE1), 1'b0, 1'b1);
    rdCheck("levelView", OFS_LEVEL_VIEW, 32'h0000_000f);
    runCase(16'h0000, 8'h00, 8'h00, bitOf(SRC_CAPTURE1), 1'b1, 1'b0);
    runCase(16'h0000, 8'h00, 8'h00, bitOf(SRC_LOW_VOLTAGE), 1'b1, 1'b0);
    rdCheck("levelView", OFS_LEVEL_VIEW, 32'h0000_07ff);
    rdCheck("eventStatus", OFS_EVENT_STATUS, 32'h0000_0007);
    print_verdict();
  end
endmodule
